// ### logic/tmw_defines.svh
// Register map, field positions and reset values of the timer mode block
`ifndef TMW_DEFINES_SVH
`define TMW_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TMW_OFF_MODE     4'h0
`define TMW_OFF_CTRL     4'h4
`define TMW_OFF_COUNT    4'h8
`define TMW_OFF_REG_A    4'hC

// ----------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------
`define TMW_MODE_RUN     7
`define TMW_MODE_RSV6    6
`define TMW_MODE_BUFB    5
`define TMW_MODE_BUFA    4
`define TMW_MODE_RSV3    3
`define TMW_MODE_PWM_D   2
`define TMW_MODE_PWM_C   1
`define TMW_MODE_PWM_B   0
`define TMW_MODE_RSV_MSK 8'h48
`define TMW_MODE_RW_MSK  8'hB7
`define TMW_MODE_RST     8'h00

// ----------------------------------------------------------------------
// Control register fields and register A reset value
// ----------------------------------------------------------------------
`define TMW_CTRL_CLR     7
`define TMW_CTRL_CKS_HI  6
`define TMW_CTRL_CKS_LO  4
`define TMW_CTRL_RST     8'h00
`define TMW_REG_A_RST    16'hFFFF

// ----------------------------------------------------------------------
// Bus answers and counter constants
// ----------------------------------------------------------------------
`define TMW_RESP_OKAY    2'h0
`define TMW_RESP_SLVERR  2'h2
`define TMW_CNT_ZERO     16'h0000
`define TMW_CNT_ONE      16'h0001
`define TMW_DIV_ONE      3'h1
`define TMW_DIV_ZERO     3'h0

`endif

// ### logic/tmw_pkg.sv
// Types shared by the timer mode block
package tmw_pkg;
	typedef enum logic [1:0]
	{
		TMW_WS_IDLE = 2'b01,
		TMW_WS_RESP = 2'b10
	} tmw_wstate_t;

	typedef enum logic [1:0]
	{
		TMW_CK_DIV1 = 2'h0,
		TMW_CK_DIV2 = 2'h1,
		TMW_CK_DIV4 = 2'h2,
		TMW_CK_DIV8 = 2'h3
	} tmw_cks_t;
endpackage

// ### logic/tmw_cnt_if.sv
// Link between the register side and the counter core
interface tmw_cnt_if;
	logic        run;
	logic        clr_en;
	logic [2:0]  cks;
	logic [15:0] general_reg_a;
	logic        ext_in;
	logic [15:0] count;
	logic        match_a;

	modport ctrl
	(
		output run, clr_en, cks, general_reg_a, ext_in,
		input  count, match_a
	);
	modport core
	(
		input  run, clr_en, cks, general_reg_a, ext_in,
		output count, match_a
	);
endinterface

// ### logic/tmw_count.sv
// Counter core: prescaler, external edge source, start and clear
`include "tmw_defines.svh"
module tmw_count
	import tmw_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	tmw_cnt_if.core   cif
);
	logic [2:0]  div_q,  div_d;
	logic        ext_q,  ext_d;
	logic [15:0] cnt_q,  cnt_d;
	logic        tick;
	logic        ext_rise;

	// ------------------------------------------------------------------
	// Count source
	// ------------------------------------------------------------------
	always_comb
	begin
		div_d    = div_q + `TMW_DIV_ONE;
		ext_d    = cif.ext_in;
		ext_rise = cif.ext_in && !ext_q;
		tick     = 1'b0;
		if (cif.cks[2])
			tick = ext_rise;
		else
		begin
			case (tmw_cks_t'(cif.cks[1:0]))
			TMW_CK_DIV1: tick = 1'b1;
			TMW_CK_DIV2: tick = (div_q[0] == 1'b0);
			TMW_CK_DIV4: tick = (div_q[1:0] == 2'h0);
			default:     tick = (div_q == `TMW_DIV_ZERO);
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	assign cif.match_a = (cnt_q == cif.general_reg_a);
	assign cif.count   = cnt_q;

	always_comb
	begin
		cnt_d = cnt_q;
		if (cif.run && tick)
		begin
			if (cif.clr_en && cif.match_a)
				cnt_d = `TMW_CNT_ZERO;
			else
				cnt_d = cnt_q + `TMW_CNT_ONE;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_q <= `TMW_DIV_ZERO;
			ext_q <= 1'b0;
			cnt_q <= `TMW_CNT_ZERO;
		end
		else
		begin
			div_q <= div_d;
			ext_q <= ext_d;
			cnt_q <= cnt_d;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	halt_hold_a: assert property (!cif.run |=> $stable(cnt_q))
		else $error("count moved while halted");
	match_clr_a: assert property (
		cif.run && tick && cif.clr_en && cif.match_a |=> cnt_q == 16'h0000)
		else $error("no clear on match A");
	free_run_a: assert property (
		cif.run && tick && !cif.clr_en |=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("free running count did not step");
	ext_edge_a: assert property (
		cif.run && cif.cks[2] && !ext_rise |=> $stable(cnt_q))
		else $error("count without external edge");
	div1_a: assert property (
		cif.run && cif.cks == 3'h0 && !cif.clr_en |=> cnt_q != $past(cnt_q))
		else $error("full rate source did not count");
	ext_cnt_c: cover property (cif.run && cif.cks[2] && ext_rise);
	clr_cnt_c: cover property (cif.run && tick && cif.clr_en && cif.match_a);
endmodule

// ### logic/tmw_mode.sv
// Timer mode select block: AXI4-Lite registers, counter and pin routing
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`include "tmw_defines.svh"
module tmw_mode
	import tmw_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ext_event_clock_in,
	input  wire logic [3:0]  chan_cmp_wave,
	input  wire logic [2:0]  chan_pwm_wave,
	input  wire logic [3:0]  chan_drive_en,
	input  wire logic        chan_a_pin_i,
	output logic             chan_a_pin_o,
	output logic             chan_a_pin_oe,
	input  wire logic        chan_b_pin_i,
	output logic             chan_b_pin_o,
	output logic             chan_b_pin_oe,
	input  wire logic        chan_c_pin_i,
	output logic             chan_c_pin_o,
	output logic             chan_c_pin_oe,
	input  wire logic        chan_d_pin_i,
	output logic             chan_d_pin_o,
	output logic             chan_d_pin_oe,
	output logic [3:0]       chan_capture_in,
	output logic             buffer_pair_a_enable,
	output logic             buffer_pair_b_enable,
	output logic [15:0]      timer_count_value,
	output logic             match_a
);
	tmw_cnt_if   cif ();
	tmw_wstate_t ws_q,     ws_d;
	logic        aw_q,     aw_d;
	logic        w_q,      w_d;
	logic [3:0]  awa_q,    awa_d;
	logic [7:0]  wdat_q,   wdat_d;
	logic        wlane_q,  wlane_d;
	logic [1:0]  bresp_q,  bresp_d;
	logic        rvalid_q, rvalid_d;
	logic [31:0] rdata_q,  rdata_d;
	logic [1:0]  rresp_q,  rresp_d;
	logic [7:0]  mode_q,   mode_d;
	logic [7:0]  ctrl_q,   ctrl_d;
	logic [15:0] general_reg_a_q, general_reg_a_d;
	logic [3:0]  cap_q,    cap_d;
	logic        aw_take;
	logic        w_take;
	logic        wr_go;
	logic [7:0]  mode_rd;

	// Byte offset is mapped when it names one of the four registers
	function automatic logic reg_hit(input logic [3:0] a);
		reg_hit = (a == `TMW_OFF_MODE) || (a == `TMW_OFF_CTRL) ||
			(a == `TMW_OFF_COUNT) || (a == `TMW_OFF_REG_A);
	endfunction

	// ------------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------------
	assign s_axi_awready = (ws_q == TMW_WS_IDLE) && !aw_q;
	assign s_axi_wready  = (ws_q == TMW_WS_IDLE) && !w_q;
	assign s_axi_bvalid  = (ws_q == TMW_WS_RESP);
	assign s_axi_bresp   = bresp_q;
	assign aw_take       = s_axi_awvalid && s_axi_awready;
	assign w_take        = s_axi_wvalid && s_axi_wready;

	always_comb
	begin
		ws_d    = ws_q;
		aw_d    = aw_q || aw_take;
		w_d     = w_q || w_take;
		awa_d   = aw_take ? s_axi_awaddr : awa_q;
		wdat_d  = w_take ? s_axi_wdata[7:0] : wdat_q;
		wlane_d = w_take ? s_axi_wstrb[0] : wlane_q;
		bresp_d = bresp_q;
		wr_go   = 1'b0;
		case (ws_q)
		TMW_WS_IDLE:
			if (aw_q && w_q)
			begin
				wr_go   = 1'b1;
				ws_d    = TMW_WS_RESP;
				aw_d    = 1'b0;
				w_d     = 1'b0;
				bresp_d = reg_hit(awa_q) ? `TMW_RESP_OKAY : `TMW_RESP_SLVERR;
			end
		TMW_WS_RESP:
			if (s_axi_bready)
				ws_d = TMW_WS_IDLE;
		default:
			ws_d = TMW_WS_IDLE;
		endcase
	end

	// ------------------------------------------------------------------
	// Registers; upper bytes are not stored, so only lane 0 matters
	// ------------------------------------------------------------------
	always_comb
	begin
		mode_d = mode_q;
		ctrl_d = ctrl_q;
		general_reg_a_d = general_reg_a_q;
		if (wr_go && wlane_q)
		begin
			if (awa_q == `TMW_OFF_MODE)
				mode_d = wdat_q & `TMW_MODE_RW_MSK;
			else if (awa_q == `TMW_OFF_CTRL)
				ctrl_d = wdat_q;
			else if (awa_q == `TMW_OFF_REG_A)
				general_reg_a_d = {general_reg_a_q[15:8], wdat_q};
		end
	end

	// ------------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------------
	assign mode_rd       = mode_q | `TMW_MODE_RSV_MSK;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_comb
	begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_d = 1'b1;
			rresp_d  = `TMW_RESP_OKAY;
			rdata_d  = 32'h0000_0000;
			if (s_axi_araddr == `TMW_OFF_MODE)
				rdata_d = {24'h00_0000, mode_rd};
			else if (s_axi_araddr == `TMW_OFF_CTRL)
				rdata_d = {24'h00_0000, ctrl_q};
			else if (s_axi_araddr == `TMW_OFF_COUNT)
				rdata_d = {16'h0000, cif.count};
			else if (s_axi_araddr == `TMW_OFF_REG_A)
				rdata_d = {16'h0000, general_reg_a_q};
			else
				rresp_d = `TMW_RESP_SLVERR;
		end
	end

	// ------------------------------------------------------------------
	// Counter core and pins
	// ------------------------------------------------------------------
	assign cif.run    = mode_q[`TMW_MODE_RUN];
	assign cif.clr_en = ctrl_q[`TMW_CTRL_CLR];
	assign cif.cks    = ctrl_q[`TMW_CTRL_CKS_HI:`TMW_CTRL_CKS_LO];
	assign cif.general_reg_a = general_reg_a_q;
	assign cif.ext_in = ext_event_clock_in;

	tmw_count u_count
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.cif     (cif)
	);

	assign timer_count_value    = cif.count;
	assign match_a              = cif.match_a;
	assign buffer_pair_a_enable = mode_q[`TMW_MODE_BUFA];
	assign buffer_pair_b_enable = mode_q[`TMW_MODE_BUFB];

	// PWM forces the pin to drive; compare mode leaves it to I/O control
	assign chan_a_pin_o  = chan_cmp_wave[0];
	assign chan_a_pin_oe = chan_drive_en[0];
	assign chan_b_pin_o  = mode_q[`TMW_MODE_PWM_B] ?
		chan_pwm_wave[0] : chan_cmp_wave[1];
	assign chan_b_pin_oe = mode_q[`TMW_MODE_PWM_B] | chan_drive_en[1];
	assign chan_c_pin_o  = mode_q[`TMW_MODE_PWM_C] ?
		chan_pwm_wave[1] : chan_cmp_wave[2];
	assign chan_c_pin_oe = mode_q[`TMW_MODE_PWM_C] | chan_drive_en[2];
	assign chan_d_pin_o  = mode_q[`TMW_MODE_PWM_D] ?
		chan_pwm_wave[2] : chan_cmp_wave[3];
	assign chan_d_pin_oe = mode_q[`TMW_MODE_PWM_D] | chan_drive_en[3];
	assign cap_d = {chan_d_pin_i, chan_c_pin_i, chan_b_pin_i, chan_a_pin_i};
	assign chan_capture_in = cap_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ws_q     <= TMW_WS_IDLE;
			aw_q     <= 1'b0;
			w_q      <= 1'b0;
			awa_q    <= 4'h0;
			wdat_q   <= 8'h00;
			wlane_q  <= 1'b0;
			bresp_q  <= `TMW_RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `TMW_RESP_OKAY;
			mode_q   <= `TMW_MODE_RST;
			ctrl_q   <= `TMW_CTRL_RST;
			general_reg_a_q <= `TMW_REG_A_RST;
			cap_q    <= 4'h0;
		end
		else
		begin
			ws_q     <= ws_d;
			aw_q     <= aw_d;
			w_q      <= w_d;
			awa_q    <= awa_d;
			wdat_q   <= wdat_d;
			wlane_q  <= wlane_d;
			bresp_q  <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
			mode_q   <= mode_d;
			ctrl_q   <= ctrl_d;
			general_reg_a_q <= general_reg_a_d;
			cap_q    <= cap_d;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	rsv_read_a: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0
		|=> s_axi_rdata[6] && s_axi_rdata[3])
		else $error("reserved mode bits not read as one");
	run_halt_a: assert property (
		wr_go && wlane_q && awa_q == `TMW_OFF_MODE
		|=> cif.run == $past(wdat_q[`TMW_MODE_RUN]))
		else $error("run bit did not follow mode write");
	buf_sel_a: assert property (
		wr_go && wlane_q && awa_q == `TMW_OFF_MODE |=>
		buffer_pair_b_enable == $past(wdat_q[`TMW_MODE_BUFB]) &&
		buffer_pair_a_enable == $past(wdat_q[`TMW_MODE_BUFA]))
		else $error("buffer select differs from mode write");
	pwm_d_a: assert property (mode_rd[2] |->
		chan_d_pin_o == chan_pwm_wave[2] && chan_d_pin_oe)
		else $error("channel D pin not on PWM");
	pwm_c_a: assert property (!mode_rd[1] |->
		chan_c_pin_o == chan_cmp_wave[2])
		else $error("channel C pin not on compare");
	pwm_b_a: assert property (mode_rd[0] |->
		chan_b_pin_o == chan_pwm_wave[0])
		else $error("channel B pin not on PWM");
	chan_a_cmp_a: assert property (
		chan_a_pin_o == chan_cmp_wave[0])
		else $error("channel A pin not on compare");
	wr_resp_a: assert property (aw_q && w_q && ws_q == TMW_WS_IDLE
		|=> s_axi_bvalid)
		else $error("write answer late");
	wr_c: cover property (s_axi_bvalid && s_axi_bready && bresp_q == 2'h0);
	rd_err_c: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	pwm_all_c: cover property (mode_q[2:0] == 3'h7 && mode_q[7]);
endmodule

// ### testbench/tmw_pin_model.sv
// Far-side model: external event source and outside pin drivers
module tmw_pin_model
(
	input  wire logic aclk,
	input  wire logic ev_go,
	output logic       ext_event,
	output logic [7:0] ev_sent,
	output logic [3:0] pin_lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] ph_q;

	initial
	begin
		ext_event = 1'b0;
		ev_sent = 8'h00;
		pin_lvl = 4'h5;
		ph_q = 3'h0;
	end

	// Released pins wander each cycle, so a stale level never passes
	always @(posedge aclk)
	begin
		pin_lvl <= {pin_lvl[2:0], pin_lvl[3] ^ pin_lvl[2]};
		ph_q <= ph_q + 3'h1;
		if (ev_go && ph_q == 3'h3)
		begin
			ext_event <= 1'b1;
			ev_sent <= ev_sent + 8'h01;
		end
		else if (ph_q == 3'h7)
			ext_event <= 1'b0;
	end
endmodule

// ### testbench/test_timer_mode_and_pin_config.sv
// Self-checking bench for the timer mode block
`include "tmw_defines.svh"
module test_timer_mode_and_pin_config;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, match_a, ev_go, ext_event_clock_in;
	logic        buffer_pair_a_enable, buffer_pair_b_enable;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [3:0]  chan_cmp_wave, chan_drive_en, chan_capture_in;
	logic [3:0]  pin_lvl, pv;
	logic [2:0]  chan_pwm_wave;
	logic [15:0] timer_count_value, c0, c1, h;
	logic [7:0]  ev_sent, e0, m;
	logic [1:0]  bq[$];
	logic [33:0] rq[$];
	wire  [3:0]  pin_o, pin_oe;
	wire  [3:0]  pin_in = (pin_oe & pin_o) | (~pin_oe & pin_lvl);
	integer      seed;
	int          mismatches, total_checks, j, k, n;

	tmw_mode dut
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .ext_event_clock_in,
		.chan_cmp_wave, .chan_pwm_wave, .chan_drive_en,
		.chan_a_pin_i(pin_in[0]), .chan_a_pin_o(pin_o[0]),
		.chan_a_pin_oe(pin_oe[0]), .chan_b_pin_i(pin_in[1]),
		.chan_b_pin_o(pin_o[1]), .chan_b_pin_oe(pin_oe[1]),
		.chan_c_pin_i(pin_in[2]), .chan_c_pin_o(pin_o[2]),
		.chan_c_pin_oe(pin_oe[2]), .chan_d_pin_i(pin_in[3]),
		.chan_d_pin_o(pin_o[3]), .chan_d_pin_oe(pin_oe[3]),
		.chan_capture_in, .buffer_pair_a_enable, .buffer_pair_b_enable,
		.timer_count_value, .match_a
	);

	tmw_pin_model far
	(
		.aclk, .ev_go, .ext_event(ext_event_clock_in), .ev_sent, .pin_lvl
	);

	// ----------------------------------------------------------------
	// Reporting
	// ----------------------------------------------------------------
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bound(input logic ok);
		if (!ok)
		begin
			mismatches++;
			complete_run();
		end
	endtask

	// ----------------------------------------------------------------
	// Bus master
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw, w, b, ra, rw, rb;
		int i;
		@(posedge aclk);
		bq.push_back(er);
		{aw, w, b} = 3'b111;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		for (i = 0; i < 40 && (aw || w || b); i++)
		begin
			@(negedge aclk);
			{ra, rw, rb} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
			@(posedge aclk);
			{aw, w, b} = {aw & ~ra, w & ~rw, b & ~rb};
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw, w, b};
		end
		bound(i < 40);
	endtask

	task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
		logic ar, r, ra, rr;
		int i;
		@(posedge aclk);
		rq.push_back(e);
		{ar, r} = 2'b11;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		for (i = 0; i < 40 && (ar || r); i++)
		begin
			@(negedge aclk);
			{ra, rr} = {s_axi_arready, s_axi_rvalid};
			@(posedge aclk);
			{ar, r} = {ar & ~ra, r & ~rr};
			{s_axi_arvalid, s_axi_rready} <= {ar, r};
		end
		bound(i < 40);
	endtask

	// Answers are paired with the oldest note of their own channel
	always @(posedge aclk)
	begin
		if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
			check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
			check(s_axi_bresp, bq.pop_front());
	end

	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		seed = 23401;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, ev_go} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
		s_axi_wstrb = 4'hF;
		{chan_cmp_wave, chan_pwm_wave, chan_drive_en} = 11'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(`TMW_OFF_MODE, 34'h48);
		axi_rd(`TMW_OFF_CTRL, 34'h0);
		axi_rd(`TMW_OFF_COUNT, 34'h0);
		axi_rd(`TMW_OFF_REG_A, 34'hFFFF);
		axi_wr(`TMW_OFF_REG_A, 32'h10, `TMW_RESP_OKAY);
		axi_rd(`TMW_OFF_REG_A, 34'hFF10);
		// Lane 0 strobe low: the write must leave the register alone
		s_axi_wstrb <= 4'hE;
		axi_wr(`TMW_OFF_REG_A, 32'h55, `TMW_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		axi_rd(`TMW_OFF_REG_A, 34'hFF10);
		axi_wr(4'h6, 32'hFF, `TMW_RESP_SLVERR);
		axi_rd(4'h2, {`TMW_RESP_SLVERR, 32'h0});
		for (j = 0; j < 32; j++)
		begin
			m = {2'b00, j[4:3], 1'b0, j[2:0]};
			axi_wr(`TMW_OFF_MODE, $random(seed) & 32'hFFFFFF48 | m,
				`TMW_RESP_OKAY);
			axi_rd(`TMW_OFF_MODE, {26'h0, m | 8'h48});
			check({buffer_pair_b_enable, buffer_pair_a_enable}, j[4:3]);
			chan_cmp_wave <= 4'($random(seed));
			chan_pwm_wave <= 3'($random(seed));
			chan_drive_en <= 4'($random(seed));
			@(negedge aclk);
			pv = pin_in;
			check({pin_o[0], pin_oe[0]}, {chan_cmp_wave[0], chan_drive_en[0]});
			for (k = 1; k < 4; k++)
				check({pin_o[k], pin_oe[k]}, m[k - 1] ? {chan_pwm_wave[k - 1], 1'b1} : {chan_cmp_wave[k], chan_drive_en[k]});
			@(negedge aclk);
			check(chan_capture_in, pv);
			@(posedge aclk);
		end
		h = 16'h0;
		for (k = 0; k < 4; k++)
		begin
			axi_wr(`TMW_OFF_CTRL, k << 4, `TMW_RESP_OKAY);
			axi_wr(`TMW_OFF_MODE, 32'h80, `TMW_RESP_OKAY);
			c0 = timer_count_value;
			check(c0 >= h && c0 - h < 16'h8, 1'b1);
			repeat (64) @(posedge aclk);
			c1 = timer_count_value - c0;
			check(c1 + 1 >= (64 >> k) && c1 <= (64 >> k) + 1, 1'b1);
			axi_wr(`TMW_OFF_MODE, 32'h0, `TMW_RESP_OKAY);
			repeat (3) @(posedge aclk);
			h = timer_count_value;
			repeat (20) @(posedge aclk);
			check(timer_count_value, h);
		end
		axi_wr(`TMW_OFF_CTRL, 32'h40 | $random(seed) & 32'h30, `TMW_RESP_OKAY);
		axi_wr(`TMW_OFF_MODE, 32'h80, `TMW_RESP_OKAY);
		c0 = timer_count_value;
		e0 = ev_sent;
		ev_go <= 1'b1;
		for (n = 0; n < 200 && ev_sent - e0 < 8'd10; n++)
			@(posedge aclk);
		ev_go <= 1'b0;
		bound(n < 200);
		repeat (12) @(posedge aclk);
		c1 = timer_count_value - c0;
		check(c1, 16'd10);
		axi_wr(`TMW_OFF_MODE, 32'h0, `TMW_RESP_OKAY);
		c0 = timer_count_value;
		ev_go <= 1'b1;
		repeat (40) @(posedge aclk);
		ev_go <= 1'b0;
		check(timer_count_value, c0);
		axi_wr(`TMW_OFF_CTRL, 32'h80, `TMW_RESP_OKAY);
		axi_rd(`TMW_OFF_CTRL, 34'h80);
		axi_wr(`TMW_OFF_MODE, 32'h80, `TMW_RESP_OKAY);
		for (n = 0; n < 70000 && match_a !== 1'b1; n++)
			@(negedge aclk);
		bound(n < 70000);
		@(negedge aclk);
		check(timer_count_value, 16'h0);
		complete_run();
	end
endmodule
